//--- src/pb_size_align_split.sv
// splitter of write requests into legal processor-bus transactions, with fifo
// What this block does
// [RULE1] Split requests into single, misaligned, extended and burst beats.
// [RULE2] Low three address bits pick the byte lane, 000 is lane 0.
// [RULE3] Single-beat size codes 0001..0111 for 1..7 bytes, 0000 for eight.
// [RULE4] A single beat never runs past the end of its doubleword.
// [RULE5] Lane choice depends on size and address only, never byte order.
// [RULE6] Misaligned single beats only when compatibility mode is set.
// [RULE7] In compatibility mode, a beat up to a word stays in one word.
// [RULE8] In compatibility mode, longer beats start or end on a word boundary.
// [RULE9] The processor keeps its misaligned transfers inside one doubleword.
// [RULE10] Software keeps the processor from unsupported misaligned transfers.
// [RULE11] Every burst starts on a 32-byte boundary, so never wraps.
// [RULE12] Unaligned starts use singles or extended beats up to the boundary.
// [RULE13] Every addressed slave accepts 32-byte bursts; nothing checks it.
// [RULE14] Extended 16 and 24 byte transfers only with the enable set.
// [RULE15] Bursts assert the burst indicator with code 0010; others negate it.
// [RULE16] Extended off: reach boundaries using beats of eight bytes or fewer.
`timescale 1ns/1ps
`default_nettype none

module pb_word_fifo
  import pb_size_align_pkg::*;
#(
  parameter int unsigned W     = 64,
  parameter int unsigned DEPTH = FIFO_WORDS
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       flush,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [W-1:0]               in_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [W-1:0]                    out_data,
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH+1);

  logic [W-1:0]  mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic          push;
  logic          pop;

  assign in_ready  = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign level     = count;
  assign push      = in_valid && in_ready && !flush;
  assign pop       = out_valid && out_ready && !flush;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH-1)) ? '0 : p + PW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule // pb_word_fifo

module pb_size_align_split
  import pb_size_align_pkg::*;
#(
  parameter int unsigned LEN_W  = 16,
  parameter int unsigned DEPTH  = FIFO_WORDS
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              ext_cycle_enable,
  input  wire logic              misalign_compat_enable,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [31:0]       req_addr,
  input  wire logic [LEN_W-1:0]  req_len,
  output logic                   req_done,
  output logic                   req_error,
  input  wire logic              wr_valid,
  output logic                   wr_ready,
  input  wire logic [63:0]       wr_data,
  output logic                   pbus_start,
  output logic [31:0]            pbus_addr,
  output logic [3:0]             pbus_size_code,
  output logic                   pbus_burst_n,
  output logic [7:0]             pbus_lane_en,
  output logic [63:0]            pbus_wdata_lanes,
  output logic                   pbus_wdata_valid,
  input  wire logic              pbus_xfer_ack_n,
  input  wire logic              pbus_beat_valid_n,
  input  wire logic              pbus_xfer_err_n
);
  localparam int unsigned CW = $clog2(DEPTH+1);

  split_state_t   state;
  logic [31:0]    cur_addr;
  logic [LEN_W-1:0] remain;
  logic [5:0]     tx_bytes;
  logic [2:0]     tx_beats;
  logic [2:0]     beats_left;
  logic           tx_pop_last;
  logic           tx_multi;

  logic [CW-1:0]  level;
  logic           fifo_pop;
  logic           fifo_flush;
  logic           fifo_valid;

  logic [2:0]     off;
  logic [4:0]     line_off;
  logic [5:0]     rem_cap;
  logic [5:0]     ext_bytes;
  logic [3:0]     single_avail;
  logic [3:0]     single_n;
  logic [5:0]     next_bytes;
  logic [2:0]     next_beats;
  logic [3:0]     next_size;
  logic           next_burst;
  logic           next_multi;
  logic [7:0]     next_lanes;
  logic           next_pop_last;
  logic           beat_ok;
  logic           last_beat;
  logic           req_last;

  function automatic logic [5:0] min6(input logic [5:0] a,
                                      input logic [5:0] b);
    min6 = (a < b) ? a : b;
  endfunction

  // largest legal single beat (at most a word without compat) at lane o with n bytes still fitting the dw
  function automatic logic [3:0] single_size(input logic [2:0] o,
                                             input logic [3:0] n,
                                             input logic       compat);
    logic [3:0] end_lane;
    single_size = 4'h1;
    end_lane    = {1'b0, o} + n;
    if (!compat) begin
      // natural alignment only
      if (o[0] || n < 4'h2) begin // RULE6
        single_size = 4'h1;
      end else if (o[1] || n < 4'h4) begin
        single_size = 4'h2;
      end else begin
        single_size = 4'h4;
      end
    end else if (o[2] || end_lane <= 4'(WORD_BYTES)) begin
      single_size = n; // RULE7
    end else if (n > 4'(WORD_BYTES) &&
                 (o == 3'h0 || end_lane == 4'(DW_BYTES))) begin
      single_size = n; // RULE8
    end else begin
      // cut back to the word boundary so the piece stays in one word
      single_size = 4'(WORD_BYTES) - {2'b00, o[1:0]}; // RULE7
    end
  endfunction

  assign off      = cur_addr[2:0]; // RULE2
  assign line_off = cur_addr[4:0];
  assign rem_cap  = (remain >= LEN_W'(LINE_BYTES)) ? 6'(LINE_BYTES)
                                                   : remain[5:0];
  assign ext_bytes = min6(6'(LINE_BYTES) - {1'b0, line_off}, rem_cap)
                     & 6'h38;
  assign single_avail = 4'(min6(6'(DW_BYTES) - {3'b000, off}, rem_cap));
  assign single_n = single_size(off, single_avail, misalign_compat_enable);

  always_comb begin
    next_bytes = {2'b00, single_n};
    next_beats = 3'h1;
    next_size  = (single_n == 4'(DW_BYTES)) ? SIZE_DW : single_n; // RULE3
    next_burst = 1'b0;
    next_multi = 1'b0;
    // RULE5
    next_lanes = 8'((16'h00FF >> (4'(DW_BYTES) - single_n)) << off);
    if (line_off == 5'h00 && remain >= LEN_W'(LINE_BYTES)) begin
      next_bytes = 6'(LINE_BYTES); // RULE11
      next_beats = 3'(BURST_BEATS);
      next_size  = SIZE_BURST; // RULE15
      next_burst = 1'b1;
      next_multi = 1'b1;
      next_lanes = LANES_ALL;
    end else if (off == 3'h0 && ext_cycle_enable &&
                 ext_bytes >= 6'(2*DW_BYTES)) begin
      next_bytes = ext_bytes; // RULE12
      next_beats = ext_bytes[5:3];
      next_size  = (ext_bytes == 6'(2*DW_BYTES)) ? SIZE_EXT16
                                                 : SIZE_EXT24; // RULE14
      next_multi = 1'b1;
      next_lanes = LANES_ALL;
    end else if (off == 3'h0 && remain >= LEN_W'(DW_BYTES)) begin
      next_bytes = 6'(DW_BYTES); // RULE16
      next_size  = SIZE_DW; // RULE4
      next_lanes = LANES_ALL;
    end
  end

  // a partial beat keeps the fifo word unless it finishes the dw or request
  assign next_pop_last = next_multi ||
      next_lanes[7] ||
      (remain == LEN_W'(next_bytes));

  assign beat_ok   = (state == ST_DATA) &&
                     (!pbus_xfer_ack_n ||
                      (ext_cycle_enable && !pbus_beat_valid_n));
  assign last_beat = beat_ok && (beats_left == 3'h1);
  assign req_last  = (remain == LEN_W'(tx_bytes));
  assign fifo_pop  = beat_ok && (tx_multi || !last_beat || tx_pop_last);
  assign fifo_flush = (state == ST_DATA) && !pbus_xfer_err_n;

  assign req_ready        = (state == ST_IDLE);
  assign pbus_start       = (state == ST_ADDR);
  assign pbus_wdata_valid = (state == ST_DATA) && fifo_valid;

  pb_word_fifo #(
    .W     (64),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (fifo_flush),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (pbus_wdata_lanes),
    .level     (level)
  );

  // sequencing of one request through its transactions
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (req_valid && req_len != '0) begin
            state <= ST_PLAN;
          end
        end
        ST_PLAN: begin
          // hold until all beats are buffered so the slave never stalls
          if (level >= CW'(next_beats)) begin
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          state <= ST_DATA;
        end
        ST_DATA: begin
          if (!pbus_xfer_err_n) begin
            state <= ST_IDLE;
          end else if (last_beat) begin
            state <= req_last ? ST_IDLE : ST_PLAN; // RULE1
          end
        end
      endcase
    end
  end

  // request progress
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_addr <= ADDR_RESET;
      remain   <= '0;
    end else if (state == ST_IDLE && req_valid) begin
      cur_addr <= req_addr;
      remain   <= req_len;
    end else if (last_beat && pbus_xfer_err_n) begin
      cur_addr <= cur_addr + 32'(tx_bytes);
      remain   <= remain - LEN_W'(tx_bytes);
    end
  end

  // transaction attributes held through address and data phases
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pbus_addr      <= ADDR_RESET;
      pbus_size_code <= SIZE_DW;
      pbus_burst_n   <= 1'b1;
      pbus_lane_en   <= LANES_NONE;
      tx_bytes       <= '0;
      tx_beats       <= '0;
      tx_multi       <= 1'b0;
      tx_pop_last    <= 1'b0;
    end else if (state == ST_PLAN && level >= CW'(next_beats)) begin
      pbus_addr      <= cur_addr;
      pbus_size_code <= next_size;
      pbus_burst_n   <= !next_burst; // RULE15
      pbus_lane_en   <= next_lanes;
      tx_bytes       <= next_bytes;
      tx_beats       <= next_beats;
      tx_multi       <= next_multi;
      tx_pop_last    <= next_pop_last;
    end else if (state == ST_IDLE) begin
      pbus_burst_n   <= 1'b1;
      pbus_lane_en   <= LANES_NONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      beats_left <= '0;
    end else if (state == ST_ADDR) begin
      beats_left <= tx_beats;
    end else if (beat_ok) begin
      beats_left <= beats_left - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_done  <= 1'b0;
      req_error <= 1'b0;
    end else begin
      req_done  <= last_beat && req_last && pbus_xfer_err_n;
      req_error <= (state == ST_DATA) && !pbus_xfer_err_n;
    end
  end
endmodule // pb_size_align_split

`default_nettype wire

//--- src/pb_size_align_pkg.sv
// constants and state type of the processor-bus size and alignment splitter
package pb_size_align_pkg;
  localparam int unsigned DW_BYTES   = 8;
  localparam int unsigned WORD_BYTES = 4;
  localparam int unsigned LINE_BYTES = 32;
  localparam int unsigned BURST_BEATS = 4;
  localparam int unsigned FIFO_WORDS = 4;
  // bit 3 is the extra size bit, bits 2:0 the ordinary size field
  localparam logic [3:0] SIZE_DW     = 4'h0;
  localparam logic [3:0] SIZE_EXT16  = 4'h9;
  localparam logic [3:0] SIZE_EXT24  = 4'hA;
  localparam logic [3:0] SIZE_BURST  = 4'h2;
  localparam logic [7:0] LANES_ALL   = 8'hFF;
  localparam logic [7:0] LANES_NONE  = 8'h00;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PLAN,
    ST_ADDR,
    ST_DATA
  } split_state_t;
endpackage

//--- testbench/pb_slave_model.sv
// behavioural 64-bit processor-bus write slave with random wait states
`timescale 1ns/1ps
`default_nettype none

module pb_slave_model
  import pb_size_align_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       stall,
  input  wire logic       ext_cycle_enable,
  input  wire logic       pbus_start,
  input  wire logic [3:0] pbus_size_code,
  input  wire logic       pbus_burst_n,
  input  wire logic       pbus_wdata_valid,
  output logic            pbus_xfer_ack_n,
  output logic            pbus_beat_valid_n,
  output logic            pbus_xfer_err_n
);
  int left = 0;

  // only terminates beats, never starts a transfer of its own
  assign pbus_xfer_err_n = 1'b1;

  initial begin
    pbus_xfer_ack_n = 1'b1;
    pbus_beat_valid_n = 1'b1;
  end

  always @(posedge clk) begin
    if (pbus_wdata_valid && (!pbus_xfer_ack_n || !pbus_beat_valid_n))
      left = left - 1;
    if (!rst_b)
      left = 0;
    else if (pbus_start)
      // every slave takes bursts, nothing asks first
      left = !pbus_burst_n ? 4 : pbus_size_code == SIZE_EXT16 ? 2 :
             pbus_size_code == SIZE_EXT24 ? 3 : 1;
    // with extended cycles on, only the final beat carries the ack
    pbus_xfer_ack_n <= !(left > 0 && !stall &&
                         (left == 1 || !ext_cycle_enable));
    pbus_beat_valid_n <= !(left > 0 && !stall && ext_cycle_enable);
  end
endmodule // pb_slave_model

`default_nettype wire

//--- testbench/pb_size_align_split_assertions.sv
// concurrent checks on the splitter's transaction outputs
`timescale 1ns/1ps
`default_nettype none

module pb_size_align_split_checker
  import pb_size_align_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ext_cycle_enable,
  input wire logic        misalign_compat_enable,
  input wire logic        pbus_start,
  input wire logic [31:0] pbus_addr,
  input wire logic [3:0]  pbus_size_code,
  input wire logic        pbus_burst_n,
  input wire logic [7:0]  pbus_lane_en,
  input wire logic        pbus_wdata_valid
);
  logic       single;
  logic [3:0] n;
  logic [3:0] last;
  logic [7:0] lanes;

  always_comb begin
    n = (pbus_size_code[2:0] == 3'h0) ? 4'h8 : {1'b0, pbus_size_code[2:0]};
    single = pbus_start && pbus_burst_n && !pbus_size_code[3];
    last = {1'b0, pbus_addr[2:0]} + n;
    lanes = 8'((16'h00FF >> (4'h8 - n)) << pbus_addr[2:0]);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  burst_code_a: assert property (
    !pbus_burst_n |-> pbus_size_code == SIZE_BURST)
    else $error("burst with wrong size code");
  burst_align_a: assert property (
    pbus_start && !pbus_burst_n |-> pbus_addr[4:0] == 5'h0)
    else $error("burst not line aligned");
  ext_gate_a: assert property (
    pbus_start && pbus_size_code[3] |-> ext_cycle_enable
      && pbus_burst_n && pbus_addr[2:0] == 3'h0)
    else $error("extended transfer not allowed");
  dw_fit_a: assert property (
    single |-> last <= 4'h8)
    else $error("single beat past doubleword");
  lane_map_a: assert property (
    single |-> pbus_lane_en == lanes)
    else $error("lane enables wrong");
  natural_a: assert property (
    single && !misalign_compat_enable |-> n inside {4'h1, 4'h2, 4'h4, 4'h8}
      && (pbus_addr[2:0] & 3'(n - 4'h1)) == 3'h0)
    else $error("misaligned beat outside compat mode");
  word_fit_a: assert property (
    single && n <= 4'h4 |-> pbus_addr[1:0] + n <= 4'h4)
    else $error("short beat crosses a word");
  word_edge_a: assert property (
    single && n > 4'h4 |-> pbus_addr[2:0] == 3'h0 || last == 4'h8)
    else $error("long beat off word edges");
  beat_ready_a: assert property (
    pbus_start |=> pbus_wdata_valid && !pbus_start)
    else $error("data not ready after start");
endmodule // pb_size_align_split_checker

bind pb_size_align_split pb_size_align_split_checker
  u_pb_size_align_split_checker (
  .clk, .rst_b, .ext_cycle_enable, .misalign_compat_enable, .pbus_start,
  .pbus_addr, .pbus_size_code, .pbus_burst_n, .pbus_lane_en,
  .pbus_wdata_valid
);

`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench of the size and alignment splitter
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pb_size_align_pkg::*;
  logic        clk, rst_b, stall, req_valid, wr_valid, rdy_s, done_s;
  logic        ext_cycle_enable, misalign_compat_enable, saw_full;
  logic        req_ready, req_done, req_error, wr_ready, pbus_start;
  logic        pbus_burst_n, pbus_wdata_valid, pbus_xfer_ack_n;
  logic        pbus_beat_valid_n, pbus_xfer_err_n;
  logic [31:0] req_addr, pbus_addr;
  logic [15:0] req_len, lfsr;
  logic [3:0]  pbus_size_code;
  logic [7:0]  pbus_lane_en;
  logic [63:0] wr_data, pbus_wdata_lanes;
  logic [39:0] got;
  logic [39:0] expq[$];
  int          num_errors, compares, beat;
  // {start address, byte count}
  logic [47:0] cases[6] = '{48'h0000_0040_0020, 48'h0000_0103_004D,
    48'h0000_0201_0007, 48'h0000_0305_0002, 48'h0000_0306_0003,
    48'h0000_0400_0060};

  pb_size_align_split u_pb_size_align_split (
    .clk, .rst_b, .ext_cycle_enable, .misalign_compat_enable, .req_valid,
    .req_ready, .req_addr, .req_len, .req_done, .req_error, .wr_valid,
    .wr_ready, .wr_data, .pbus_start, .pbus_addr, .pbus_size_code,
    .pbus_burst_n, .pbus_lane_en, .pbus_wdata_lanes, .pbus_wdata_valid,
    .pbus_xfer_ack_n, .pbus_beat_valid_n, .pbus_xfer_err_n
  );

  pb_slave_model u_pb_slave_model (
    .clk, .rst_b, .stall, .ext_cycle_enable, .pbus_start, .pbus_size_code,
    .pbus_burst_n, .pbus_wdata_valid, .pbus_xfer_ack_n, .pbus_beat_valid_n,
    .pbus_xfer_err_n
  );

  function automatic logic [15:0] rand16();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // one request; its bytes are noted in address order
  task automatic run(input logic [31:0] a, input logic [15:0] n);
    logic [63:0] w;
    int t;
    req_valid <= 1'b1;
    req_addr <= a;
    req_len <= n;
    @(posedge clk);
    req_valid <= 1'b0;
    for (int d = a >> 3; d <= (a + n - 1) >> 3; d++) begin
      w = {rand16(), rand16(), rand16(), rand16()};
      for (int b = 0; b < 8; b++)
        if (d * 8 + b >= a && d * 8 + b < a + n)
          expq.push_back({32'(d * 8 + b), w[8 * b +: 8]});
      wr_valid <= 1'b1;
      wr_data <= w;
      do @(posedge clk); while (rdy_s !== 1'b1);
    end
    wr_valid <= 1'b0;
    t = 0;
    while (done_s !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    check({39'h0, done_s}, 40'h1);
    check(40'(expq.size()), 40'h0);
  endtask

  // outputs are settled by the falling edge, so no race with the design
  always @(negedge clk) begin
    rdy_s = wr_ready;
    done_s = req_done;
    if (done_s)
      check({39'h0, req_ready}, 40'h1);
    if (pbus_start)
      check({39'h0, req_ready}, 40'h0);
    if (wr_valid && !wr_ready)
      saw_full = 1'b1;
    if (req_error)
      check(40'h1, 40'h0);
    if (pbus_start)
      beat = 0;
    if (rst_b && pbus_wdata_valid && (!pbus_xfer_ack_n ||
        (ext_cycle_enable && !pbus_beat_valid_n))) begin
      for (int l = 0; l < 8; l++)
        if (pbus_lane_en[l]) begin
          got = {29'(pbus_addr[31:3] + beat), 3'(l),
                 pbus_wdata_lanes[8 * l +: 8]};
          check(got, expq.pop_front());
        end
      beat++;
    end
  end

  always @(posedge clk)
    stall <= rand16() > 16'hA000;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    {rst_b, req_valid, wr_valid, stall, saw_full} = '0;
    {ext_cycle_enable, misalign_compat_enable} = '0;
    {req_addr, req_len, wr_data} = '0;
    lfsr = 16'h5A43;
    num_errors = 0;
    compares = 0;
    beat = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      ext_cycle_enable <= m[0];
      misalign_compat_enable <= m[1];
      @(posedge clk);
      // a zero length request is taken but must start nothing
      req_valid <= 1'b1;
      req_len <= '0;
      @(posedge clk);
      foreach (cases[i])
        run(cases[i][47:16], cases[i][15:0]);
      repeat (8)
        run({16'h0, rand16()}, 16'(rand16() % 16'h64 + 16'h1));
    end
    check({39'h0, saw_full}, 40'h1);
    tally_and_finish();
  end

  // about 56 requests of under 200 cycles each
  initial begin
    #3000000;
    num_errors++;
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
